// ### dsef_status.sv
`timescale 1ns/1ps
module dsef_status #(
    parameter logic [15:0] RECOVERY_TICKS = 16'h0064 // supply_recovery_time in ticks
) (
    input  wire logic       clk_sys_in,
    input  wire logic       arst_n_in,
    input  wire logic       tick_in,
    input  wire logic       bus_input_uv_in,
    input  wire logic       buffer_uv_in,
    input  wire logic       buffer_ov_in,
    input  wire logic       analog_reg_bad_in,
    input  wire logic       digital_reg_bad_in,
    input  wire logic       memory_reg_bad_in,
    input  wire logic       continuity_break_in,
    input  wire logic       factory_otp_fault_in,
    input  wire logic       user_otp_fault_in,
    input  wire logic       otp_write_busy_in,
    input  wire logic       temp_fault_in,
    input  wire logic       osc_train_fault_in,
    input  wire logic       init_complete_lock_in,
    input  wire logic [7:0] check_code_in,
    input  wire logic [7:0] check_ref_in,
    input  wire logic       supply_report_disable_in,
    input  wire logic       second_mode_in,
    input  wire logic       rd_in,
    input  wire logic [7:0] rd_addr_in,
    input  wire logic       report_supply_in,
    input  wire logic       report_memtemp_in,
    input  wire logic       report_comm_in,
    output logic [7:0]      rd_data_out,
    output logic            tx_mute_out,
    output logic [7:0]      supply_status_out,
    output logic [7:0]      memory_temp_status_out,
    output logic [7:0]      comm_status_out
);
    // ****************************************************************
    // shared decode helpers
    // ****************************************************************

    // one decode for every read-clear; the read mux keeps its own case on the same offsets;
    // a mismatch here would let a read clear a flag it never returned
    function automatic logic read_hits(input logic       rd,
                                       input logic [7:0] addr,
                                       input logic [7:0] ofs);
        read_hits = rd && (addr == ofs);
    endfunction

    // sticky flag update: a clear drops old bits, live faults always win;
    // the supply and memory groups use it; the comm flag repeats the set-wins rule inline
    function automatic logic [7:0] sticky_next(input logic [7:0] cur,
                                               input logic       clr,
                                               input logic [7:0] now);
        sticky_next = (clr ? 8'h00 : cur) | now;
    endfunction

    // ****************************************************************
    // live supply conditions
    // ****************************************************************
    logic [7:0] sup_now;
    logic       sup_any;

    // each monitor lands on its status bit; bit 4 stays reserved at zero
    // so a read of the supply register never shows a phantom fault
    always_comb begin
        sup_now                       = 8'h00;
        // undervoltage monitors
        sup_now[dsef_pkg::BUFUV_BIT]  = buffer_uv_in;
        sup_now[dsef_pkg::BUSUV_BIT]  = bus_input_uv_in;
        // buffered supply upper limit
        sup_now[dsef_pkg::BUFOV_BIT]  = buffer_ov_in;
        // internal regulator windows
        sup_now[dsef_pkg::ANAREG_BIT] = analog_reg_bad_in;
        sup_now[dsef_pkg::DIGREG_BIT] = digital_reg_bad_in;
        sup_now[dsef_pkg::MEMREG_BIT] = memory_reg_bad_in;
        // package perimeter loop
        sup_now[dsef_pkg::CONT_BIT]   = continuity_break_in;
        // one summary feeds both the timer reload and the mute
        sup_any                       = |sup_now;
    end

    // ****************************************************************
    // shared recovery timer
    // ****************************************************************
    logic [dsef_pkg::TIMER_W-1:0] tmr_q;
    logic [dsef_pkg::TIMER_W-1:0] tmr_d;
    logic                         tmr_zero;

    // reload while any error, else count down per tick and hold at zero;
    // a fault that flickers keeps restarting the whole recovery window
    always_comb begin
        if (sup_any) begin
            tmr_d = RECOVERY_TICKS;
        end else if (tick_in && (tmr_q != dsef_pkg::TIMER_RESET)) begin
            tmr_d = tmr_q - 16'h0001;
        end else begin
            tmr_d = tmr_q;
        end
        // expiry as seen by the clearing logic
        tmr_zero = (tmr_q == dsef_pkg::TIMER_RESET);
    end

    // timer starts expired, so a clean power-up is not muted;
    // the reload value is a parameter because the real duration is long
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tmr_q <= dsef_pkg::TIMER_RESET;
        end else begin
            tmr_q <= tmr_d;
        end
    end

    // ****************************************************************
    // supply flags and their clearing policy
    // ****************************************************************
    logic [7:0] sup_q;
    logic [7:0] sup_d;
    logic       sup_quiet_mode;
    logic       sup_clr_auto;
    logic       sup_clr_rd;

    // muted setups clear on expiry alone; the reporting setup needs a read
    // or a report, and even then only once the timer has run out
    always_comb begin
        // either setting keeps the link silent during recovery
        sup_quiet_mode = second_mode_in || supply_report_disable_in;
        // muted setups: expiry alone clears
        sup_clr_auto   = sup_quiet_mode && tmr_zero;
        // reporting setup: read or report, after expiry
        sup_clr_rd     = !sup_quiet_mode && tmr_zero
                         && (read_hits(rd_in, rd_addr_in, dsef_pkg::SUPPLY_STATUS_OFS)
                             || report_supply_in);
        // set wins over clear, so a present fault never drops
        sup_d          = sticky_next(sup_q, sup_clr_auto || sup_clr_rd, sup_now);
    end

    // supply flags start clear after reset
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sup_q <= dsef_pkg::FLAGS_RESET;
        end else begin
            sup_q <= sup_d;
        end
    end

    // ****************************************************************
    // memory and temperature flags
    // ****************************************************************
    logic [7:0] mt_q;
    logic [7:0] mt_d;
    logic [7:0] mt_now;
    logic       mt_clr;

    // checksum only watched once the init lock is set; before that the
    // user may still be writing registers, so a mismatch means nothing
    always_comb begin
        mt_now                     = 8'h00;
        // one-time memory arrays
        mt_now[dsef_pkg::FOTP_BIT] = factory_otp_fault_in;
        mt_now[dsef_pkg::UOTP_BIT] = user_otp_fault_in;
        // register check code against its reference
        mt_now[dsef_pkg::URW_BIT]  = init_complete_lock_in
                                     && (check_code_in != check_ref_in);
        // over or under temperature
        mt_now[dsef_pkg::TEMP_BIT] = temp_fault_in;
        // a read of this register or a report of it clears the sticky bits
        mt_clr = read_hits(rd_in, rd_addr_in, dsef_pkg::MEM_TEMP_OFS)
                 || report_memtemp_in;
        mt_d   = sticky_next(mt_q, mt_clr, mt_now);
        // write-active is a live status, not sticky, and no read touches it
        mt_d[dsef_pkg::UWACT_BIT] = otp_write_busy_in;
        // reserved positions are forced low whatever the sticky path holds
        mt_d[3] = 1'b0;
        mt_d[1] = 1'b0;
        mt_d[0] = 1'b0;
    end

    // defined bits start clear after reset
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mt_q <= dsef_pkg::FLAGS_RESET;
        end else begin
            mt_q <= mt_d;
        end
    end

    // ****************************************************************
    // communication flag
    // ****************************************************************
    logic [7:0] comm_v;
    logic       osc_q;
    logic       osc_d;
    logic       osc_clr;

    // bit 7 and the reserved bits read zero; only the training flag lives
    // here, so it needs no byte-wide sticky helper
    always_comb begin
        // cleared like the memory flags: read or report
        osc_clr = read_hits(rd_in, rd_addr_in, dsef_pkg::COMM_STATUS_OFS)
                  || report_comm_in;
        osc_d   = (osc_q && !osc_clr) || osc_train_fault_in;
        // image used by the read mux
        comm_v                      = 8'h00;
        comm_v[dsef_pkg::OSCTR_BIT] = osc_q;
    end

    // training flag starts clear after reset
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= osc_d;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    logic [7:0] rdd_d;

    // read returns pre-clear contents, so the reader sees what it cleared;
    // unmapped offsets and idle cycles read zero
    always_comb begin
        rdd_d = 8'h00;
        if (rd_in) begin
            unique case (rd_addr_in)
                dsef_pkg::SUPPLY_STATUS_OFS: rdd_d = sup_q;
                dsef_pkg::MEM_TEMP_OFS:      rdd_d = mt_q;
                dsef_pkg::COMM_STATUS_OFS:   rdd_d = comm_v;
                default:                     rdd_d = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    logic [7:0] comm_d;
    logic       mute_d;

    // mute follows the next timer value so it drops on the very edge the
    // timer expires, not one cycle late
    always_comb begin
        mute_d                      = sup_any || (tmr_d != dsef_pkg::TIMER_RESET);
        // communication image tracks the next flag state
        comm_d                      = 8'h00;
        comm_d[dsef_pkg::OSCTR_BIT] = osc_d;
    end

    // every output comes straight from a flip-flop; images use next state
    // so they match the internal flag registers cycle for cycle
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_data_out            <= 8'h00;
            tx_mute_out            <= 1'b0;
            supply_status_out      <= dsef_pkg::FLAGS_RESET;
            memory_temp_status_out <= dsef_pkg::FLAGS_RESET;
            comm_status_out        <= dsef_pkg::FLAGS_RESET;
        end else begin
            rd_data_out            <= rdd_d;
            tx_mute_out            <= mute_d;
            supply_status_out      <= sup_d;
            memory_temp_status_out <= mt_d;
            comm_status_out        <= comm_d;
        end
    end
endmodule

// ### dsef_pkg.sv
package dsef_pkg;
    localparam logic [7:0] SUPPLY_STATUS_OFS = 8'h02;
    localparam logic [7:0] MEM_TEMP_OFS      = 8'h03;
    localparam logic [7:0] COMM_STATUS_OFS   = 8'h04;
    localparam int BUFUV_BIT  = 7;
    localparam int BUSUV_BIT  = 6;
    localparam int BUFOV_BIT  = 5;
    localparam int ANAREG_BIT = 3;
    localparam int DIGREG_BIT = 2;
    localparam int MEMREG_BIT = 1;
    localparam int CONT_BIT   = 0;
    localparam int FOTP_BIT   = 7;
    localparam int UOTP_BIT   = 6;
    localparam int URW_BIT    = 5;
    localparam int UWACT_BIT  = 4;
    localparam int TEMP_BIT   = 2;
    localparam int OSCTR_BIT  = 6;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam int TIMER_W = 16;
    localparam logic [15:0] TIMER_RESET = 16'h0000;
endpackage

// ### dsef_chk.sv
`timescale 1ns/1ps
// ********
// status flag checker
// ********
module dsef_chk (
    input wire logic       clk_sys_in,
    input wire logic       arst_n_in,
    input wire logic       rd_in,
    input wire logic [7:0] rd_addr_in,
    input wire logic       bus_input_uv_in,
    input wire logic       temp_fault_in,
    input wire logic       osc_train_fault_in,
    input wire logic [7:0] rd_data_out,
    input wire logic       tx_mute_out,
    input wire logic [7:0] supply_status_out,
    input wire logic [7:0] memory_temp_status_out,
    input wire logic [7:0] comm_status_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    // live conditions must show one edge later, whatever the clearing policy
    property p_uv; bus_input_uv_in |=> supply_status_out[6]; endproperty
    a_uv: assert property (p_uv) else $error("bus uv flag missing");
    property p_tmp; temp_fault_in |=> memory_temp_status_out[2]; endproperty
    a_tmp: assert property (p_tmp) else $error("temp flag missing");
    property p_osc; osc_train_fault_in |=> comm_status_out[6]; endproperty
    a_osc: assert property (p_osc) else $error("osc flag missing");
    property p_mute; bus_input_uv_in |=> tx_mute_out [*2]; endproperty
    a_mute: assert property (p_mute) else $error("mute dropped early");
    property p_rsv; !supply_status_out[4] && memory_temp_status_out[3] ~^ 1'b0
        && memory_temp_status_out[1:0] == 2'b00 && comm_status_out[7] == 1'b0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    // a read answers with the image as it stood before any clear
    property p_rdmt; rd_in && rd_addr_in == 8'h03 |=> rd_data_out == $past(memory_temp_status_out);
    endproperty
    a_rdmt: assert property (p_rdmt) else $error("read data wrong");
    property p_clr; rd_in && rd_addr_in == 8'h03 && !temp_fault_in |=> !memory_temp_status_out[2];
    endproperty
    a_clr: assert property (p_clr) else $error("temp flag not cleared");
    property p_idle; !rd_in |=> rd_data_out == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data held");
    c_rd2: cover property (rd_in && rd_addr_in == 8'h02);
    c_rd3: cover property (rd_in && rd_addr_in == 8'h03 && temp_fault_in);
    c_mute: cover property ($fell(tx_mute_out));
endmodule
bind dsef_status dsef_chk u_dsef_chk (.*);

// ### dsef_master.sv
`timescale 1ns/1ps
// ********
// remote reader on the sensor link
// ********
module dsef_master (
    input  wire logic       clk_sys_in,
    input  wire logic [7:0] rd_data_out,
    output logic            rd_in,
    output logic [7:0]      rd_addr_in
);
    initial begin
        rd_in = 1'b0;
        rd_addr_in = 8'h00;
    end
    // request stands from one falling edge to the next, so one rising edge takes it
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_in);
        rd_in = 1'b1;
        rd_addr_in = a;
        @(negedge clk_sys_in);
        d = rd_data_out;
        rd_in = 1'b0;
        rd_addr_in = ~a; // a released address never keeps its last value
    endtask
endmodule

// ### tb_dsef_status.sv
`timescale 1ns/1ps
// ********
// status flag bench
// ********
module tb_dsef_status;
    localparam int RT = 4;
    logic clk_sys_in, arst_n_in, tick_in, rd_in, osc_train_fault_in, tx_mute_out;
    logic bus_input_uv_in, buffer_uv_in, buffer_ov_in, analog_reg_bad_in, digital_reg_bad_in;
    logic memory_reg_bad_in, continuity_break_in, factory_otp_fault_in, user_otp_fault_in;
    logic otp_write_busy_in, temp_fault_in, init_complete_lock_in, supply_report_disable_in;
    logic second_mode_in, report_supply_in, report_memtemp_in, report_comm_in;
    logic [7:0] rd_addr_in, rd_data_out, check_code_in, check_ref_in, d, sv;
    logic [7:0] supply_status_out, memory_temp_status_out, comm_status_out;
    logic [15:0] rows [7] = '{16'h8080, 16'h4040, 16'h2020, 16'h0808, 16'h0404, 16'h0202, 16'h0101};
    int fails = 0, samples_checked = 0, n;
    assign {buffer_uv_in, bus_input_uv_in, buffer_ov_in} = sv[7:5];
    assign {analog_reg_bad_in, digital_reg_bad_in, memory_reg_bad_in, continuity_break_in} = sv[3:0];
    dsef_status #(.RECOVERY_TICKS(16'(RT))) u_dsef_status (.*);
    dsef_master u_dsef_master (.*);
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic results;
        if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // table of supply faults in the two muting setups, then hand-made cases
    initial begin
        {sv, factory_otp_fault_in, user_otp_fault_in, otp_write_busy_in, temp_fault_in} = '0;
        {osc_train_fault_in, init_complete_lock_in, supply_report_disable_in} = '0;
        {second_mode_in, report_supply_in, report_memtemp_in, report_comm_in} = '0;
        {check_code_in, check_ref_in, arst_n_in} = '0;
        tick_in = 1'b1;
        repeat (6) @(negedge clk_sys_in);
        chk(supply_status_out | memory_temp_status_out | comm_status_out, 8'h00);
        arst_n_in = 1'b1;
        for (int i = 0; i < 7; i++) begin
            {second_mode_in, supply_report_disable_in} = i[0] ? 2'b10 : 2'b01;
            sv = rows[i][15:8];
            repeat (3) @(negedge clk_sys_in); // held fault keeps reloading the timer
            chk(supply_status_out, rows[i][7:0]);
            sv = 8'h00;
            n = 0;
            while (tx_mute_out === 1'b1 && n < 20) begin
                @(negedge clk_sys_in);
                n++;
            end
            if (n == 20) begin
                fails++;
                results();
            end
            chk(8'(n), 8'(RT));
            @(negedge clk_sys_in);
            chk(supply_status_out, 8'h00);
        end
        {second_mode_in, supply_report_disable_in} = 2'b00;
        sv = 8'h40;
        @(negedge clk_sys_in);
        sv = 8'h00;
        u_dsef_master.read(8'h02, d);
        chk(supply_status_out, 8'h40);
        repeat (6) @(negedge clk_sys_in);
        u_dsef_master.read(8'h02, d);
        chk(d ^ supply_status_out, 8'h40);
        sv = 8'h01;
        @(negedge clk_sys_in);
        sv = 8'h00;
        repeat (6) @(negedge clk_sys_in);
        chk(supply_status_out, 8'h01);
        report_supply_in = 1'b1;
        @(negedge clk_sys_in);
        report_supply_in = 1'b0;
        chk(supply_status_out, 8'h00);
        {factory_otp_fault_in, user_otp_fault_in, otp_write_busy_in, temp_fault_in} = 4'hf;
        init_complete_lock_in = 1'b1;
        check_code_in = 8'h5a;
        @(negedge clk_sys_in);
        chk(memory_temp_status_out, 8'hf4);
        {factory_otp_fault_in, user_otp_fault_in, otp_write_busy_in} = 3'h0;
        {check_code_in, init_complete_lock_in} = '0;
        u_dsef_master.read(8'h03, d);
        chk(d ^ memory_temp_status_out, 8'he0);
        temp_fault_in = 1'b0;
        check_code_in = 8'h33; // mismatch without the lock must stay silent
        @(negedge clk_sys_in);
        report_memtemp_in = 1'b1;
        @(negedge clk_sys_in);
        report_memtemp_in = 1'b0;
        chk(memory_temp_status_out, 8'h00);
        osc_train_fault_in = 1'b1;
        u_dsef_master.read(8'h04, d);
        chk(d, 8'h40);
        u_dsef_master.read(8'h07, d);
        chk(d, 8'h00);
        // mid-run reset with a live training fault: all images drop, then it returns
        arst_n_in = 1'b0;
        @(negedge clk_sys_in);
        chk(supply_status_out | memory_temp_status_out | comm_status_out, 8'h00);
        chk(rd_data_out | {7'h00, tx_mute_out}, 8'h00);
        arst_n_in = 1'b1;
        @(negedge clk_sys_in);
        chk(comm_status_out, 8'h40);
        results();
    end
endmodule
